// [tsens_smbus_slave.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] Acts only as slave; supports write byte, write word, read byte, read word.
// [RULE2] Low slave address bits come from strapped address-select pins.
// [RULE3] Address-select pin count is a variant parameter: two, three or four.
// [RULE4] Command byte loads the pointer; data phase targets the pointed register.
// [RULE5] Smallest variant: pointer selects only temperature and configuration.
// [RULE6] Temperature is read-only, 16 bits, 13-bit result on top, low three zero; the 2-pin variant puts status flags in all three.
// [RULE7] Mid variant: low two bits are status flags, bit two unused.
// [RULE8] Result is two's complement Celsius, LSB equals 0.0625 degrees.
// [RULE9] Configuration is 8-bit read/write: timeout disable, fault queue, shutdown.
// [RULE10] Mid variant: pointer also selects high limit, low limit, hysteresis.
// [RULE11] Conversions run continuously; latest result readable any time.
// [RULE12] Write byte: start, address+W, command, data, stop; each byte acknowledged.
// [RULE13] Read: command write, repeated start, address+R, then device drives data.
// [RULE14] Master NACKs last read byte and then issues stop.
// [RULE15] Temperature read aborts conversion; otherwise a new result every 500 ms.
// [RULE16] Clock held low 25 ms mid-transfer resets interface unless disabled.
// [RULE17] Two-byte transfers go most significant byte first in both directions.
module tsens_smbus_slave
    import tsens_pkg::*;
#(
    parameter int ADDR_PINS = 3,
    parameter logic [6:0] BASE_ADDR = 7'h48, // Arbitrary value
    parameter int CONV_CYCLES = CONV_CYCLES_DEF,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
) (
    input wire logic clk_i, // 200 MHz clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic scl_i, // Serial clock
    input wire logic sda_i, // Serial data in
    output logic sda_o, // Serial data out, always low
    output logic sda_oe_n_o, // Low while pulling data low
    input wire logic [3:0] address_select_i, // Strap pins, bit n = address_select_bitn
    input wire logic [RESULT_W-1:0] temp_sample_i, // Converter output
    input wire logic [2:0] status_flags_i, // Alarm status from converter side
    output logic conv_done_o, // Pulse: new result stored
    output logic conv_abort_o, // Pulse: conversion aborted by read
    output logic [15:0] temperature_o, // Temperature register
    output tsens_regs_t regs_o, // Writable registers
    output logic shutdown_o, // Configuration shutdown control
    output logic fault_queue_en_o // Configuration fault queue control
);

    localparam int PINS = (ADDR_PINS < 2) ? 2 : ((ADDR_PINS > 4) ? 4 : ADDR_PINS); // [RULE3]
    localparam bit SMALL = (PINS == 4);

    logic rst_s1_reg, rst_s2_reg, rst_n;
    logic scl_q_reg, sda_q_reg;
    logic scl_rise, scl_fall, start_det, stop_det;
    tsens_state_t state_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] pointer_reg;
    logic [15:0] tx_reg;
    logic data_idx_reg;
    logic master_ack_reg;
    logic sda_low_reg;
    logic [15:0] temperature_value_reg;
    tsens_regs_t regs_reg;
    logic [CONV_CNT_W-1:0] conv_cnt_reg;
    logic conv_done_reg, conv_abort_reg;
    logic [TO_CNT_W-1:0] to_cnt_reg;
    logic timeout;
    logic [6:0] own_addr;
    logic [15:0] read_word;
    logic temp_read;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // Pointer decode shared by read mux and write path
    function automatic logic ptr_valid(input logic [7:0] p);
        if (p == PTR_TEMP || p == PTR_CONF) begin
            return 1'b1;
        end
        return !SMALL && (p == PTR_HYST || p == PTR_TLOW || p == PTR_THIGH); // [RULE5] [RULE10]
    endfunction

    // Strap bits replace the low address bits
    genvar gi;
    generate
        for (gi = 0; gi < SLV_ADDR_W; gi++) begin : g_addr
            if (gi < PINS) begin : g_pin
                assign own_addr[gi] = address_select_i[gi]; // [RULE2]
            end else begin : g_base
                assign own_addr[gi] = BASE_ADDR[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_i;
            sda_q_reg <= sda_i;
        end
    end
    assign scl_rise = !scl_q_reg && scl_i;
    assign scl_fall = scl_q_reg && !scl_i;
    assign start_det = scl_q_reg && scl_i && sda_q_reg && !sda_i;
    assign stop_det = scl_q_reg && scl_i && !sda_q_reg && sda_i;

    always_comb begin
        read_word = 16'h0000;
        if (ptr_valid(pointer_reg)) begin
            case (pointer_reg)
                PTR_TEMP: read_word = temperature_value_reg;
                PTR_CONF: read_word = {regs_reg.config_byte, 8'h00};
                PTR_HYST: read_word = regs_reg.hyst;
                PTR_TLOW: read_word = regs_reg.limit_low;
                PTR_THIGH: read_word = regs_reg.limit_high;
                default: read_word = 16'h0000;
            endcase
        end
    end

    assign timeout = (state_reg != ST_IDLE) && !regs_reg.config_byte[CONF_TO_DIS_BIT]
        && (to_cnt_reg >= TO_CNT_W'(TIMEOUT_CYCLES)); // [RULE16]
    assign temp_read = scl_fall && state_reg == ST_ADDR_ACK && shift_reg[0]
        && pointer_reg == PTR_TEMP;

    // Clock-low watchdog
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            to_cnt_reg <= '0;
        end else if (scl_i || state_reg == ST_IDLE || timeout) begin
            to_cnt_reg <= '0;
        end else begin
            to_cnt_reg <= to_cnt_reg + 1'b1; // [RULE16]
        end
    end

    // Serial protocol engine; slave only, never drives the clock
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= '0;
            shift_reg <= 8'h00;
            pointer_reg <= PTR_TEMP;
            tx_reg <= 16'h0000;
            data_idx_reg <= 1'b0;
            master_ack_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end else if (timeout || stop_det) begin
            state_reg <= ST_IDLE;
            sda_low_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= ST_ADDR; // [RULE13]
            bit_cnt_reg <= '0;
            sda_low_reg <= 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    shift_reg <= {shift_reg[6:0], sda_i};
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                end
                ST_RDATA_ACK: master_ack_reg <= !sda_i; // [RULE14]
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        bit_cnt_reg <= '0;
                        if (shift_reg[7:1] == own_addr) begin
                            state_reg <= ST_ADDR_ACK; // [RULE12]
                            sda_low_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    data_idx_reg <= 1'b0;
                    if (shift_reg[0]) begin
                        state_reg <= ST_RDATA; // [RULE13]
                        sda_low_reg <= !read_word[15];
                        tx_reg <= {read_word[14:0], 1'b0};
                        bit_cnt_reg <= 4'h1;
                    end else begin
                        state_reg <= ST_CMD;
                        sda_low_reg <= 1'b0;
                    end
                end
                ST_CMD: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        pointer_reg <= shift_reg; // [RULE4]
                        bit_cnt_reg <= '0;
                        state_reg <= ST_CMD_ACK;
                        sda_low_reg <= 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        bit_cnt_reg <= '0;
                        data_idx_reg <= 1'b1;
                        state_reg <= ST_WDATA_ACK;
                        sda_low_reg <= 1'b1; // [RULE12]
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK: begin
                    state_reg <= ST_WDATA;
                    sda_low_reg <= 1'b0;
                end
                ST_RDATA: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        state_reg <= ST_RDATA_ACK;
                        sda_low_reg <= 1'b0;
                    end else begin
                        sda_low_reg <= !tx_reg[15]; // [RULE17]
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                    end
                end
                ST_RDATA_ACK: begin
                    if (master_ack_reg) begin
                        state_reg <= ST_RDATA;
                        sda_low_reg <= !tx_reg[15];
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        bit_cnt_reg <= 4'h1;
                    end else begin
                        state_reg <= ST_IDLE; // [RULE14]
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Register writes land on the fall that ends each data byte
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            regs_reg <= '{config_byte: CONF_RESET, hyst: LIMIT_RESET,
                          limit_low: LIMIT_RESET, limit_high: LIMIT_RESET};
        end else if (scl_fall && state_reg == ST_WDATA && bit_cnt_reg == BITS_PER_BYTE
                     && ptr_valid(pointer_reg)) begin // [RULE4]
            case (pointer_reg)
                PTR_CONF: if (!data_idx_reg) regs_reg.config_byte <= shift_reg; // [RULE9]
                PTR_HYST: begin
                    if (!data_idx_reg) regs_reg.hyst[15:8] <= shift_reg; // [RULE17]
                    else regs_reg.hyst[7:0] <= shift_reg;
                end
                PTR_TLOW: begin
                    if (!data_idx_reg) regs_reg.limit_low[15:8] <= shift_reg;
                    else regs_reg.limit_low[7:0] <= shift_reg;
                end
                PTR_THIGH: begin
                    if (!data_idx_reg) regs_reg.limit_high[15:8] <= shift_reg;
                    else regs_reg.limit_high[7:0] <= shift_reg;
                end
                default: ; // Temperature is read-only
            endcase
        end
    end

    // Conversion timer; shutdown holds it at zero, a temperature read restarts it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt_reg <= '0;
            conv_done_reg <= 1'b0;
            conv_abort_reg <= 1'b0;
            temperature_value_reg <= 16'h0000;
        end else begin
            conv_done_reg <= 1'b0;
            conv_abort_reg <= temp_read; // [RULE15]
            if (temp_read || regs_reg.config_byte[CONF_SHUTDOWN_BIT]) begin
                conv_cnt_reg <= '0; // [RULE15]
            end else if (conv_cnt_reg >= CONV_CNT_W'(CONV_CYCLES - 1)) begin
                conv_cnt_reg <= '0;
                conv_done_reg <= 1'b1;
                temperature_value_reg[15:RESULT_LSB] <= temp_sample_i; // [RULE6] [RULE8] [RULE11]
                if (SMALL) begin
                    temperature_value_reg[RESULT_LSB-1:0] <= 3'h0; // [RULE6]
                end else if (PINS == 3) begin
                    temperature_value_reg[RESULT_LSB-1:0] <= {1'b0, status_flags_i[1:0]}; // [RULE7]
                end else begin
                    temperature_value_reg[RESULT_LSB-1:0] <= status_flags_i;
                end
            end else begin
                conv_cnt_reg <= conv_cnt_reg + 1'b1; // [RULE15]
            end
        end
    end

    assign sda_o = 1'b0; // [RULE1]
    assign sda_oe_n_o = !sda_low_reg;
    assign conv_done_o = conv_done_reg;
    assign conv_abort_o = conv_abort_reg;
    assign temperature_o = temperature_value_reg;
    assign regs_o = regs_reg;
    assign shutdown_o = regs_reg.config_byte[CONF_SHUTDOWN_BIT]; // [RULE9]
    assign fault_queue_en_o = regs_reg.config_byte[CONF_FAULTQ_BIT];

endmodule // tsens_smbus_slave
`default_nettype wire

// [tsens_pkg.sv]
`default_nettype none
package tsens_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 200;
    localparam int CONV_TIME_MS = 500;
    localparam int CONV_CYCLES_DEF = CONV_TIME_MS * 1000 * CLK_MHZ;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYCLES_DEF = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int CONV_CNT_W = 27;
    localparam int TO_CNT_W = 23;

    // Pointer codes
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CONF = 8'h01;
    localparam logic [7:0] PTR_HYST = 8'h02;
    localparam logic [7:0] PTR_TLOW = 8'h03;
    localparam logic [7:0] PTR_THIGH = 8'h04;

    // Configuration fields
    localparam int CONF_SHUTDOWN_BIT = 0;
    localparam int CONF_FAULTQ_BIT = 3;
    localparam int CONF_TO_DIS_BIT = 7;
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;

    // Slave address, bit counter and result layout
    localparam int SLV_ADDR_W = 7;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int RESULT_W = 13;
    localparam int RESULT_LSB = 3;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } tsens_state_t;

    typedef struct packed {
        logic [7:0] config_byte;
        logic [15:0] hyst;
        logic [15:0] limit_low;
        logic [15:0] limit_high;
    } tsens_regs_t;
endpackage
`default_nettype wire

// [tsens_smbus_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module tsens_smbus_chk
    import tsens_pkg::*;
#(
    parameter int ADDR_PINS = 3,
    parameter int CONV_CYCLES = 200,
    parameter int TIMEOUT_CYCLES = 500
) (
    input wire logic clk_i, // Clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic scl_i, // Serial clock
    input wire logic sda_o, // Data drive level
    input wire logic sda_oe_n_o, // Low while pulling data
    input wire logic [RESULT_W-1:0] temp_sample_i, // Converter result
    input wire logic [2:0] status_flags_i, // Status inputs
    input wire logic conv_done_o, // New result pulse
    input wire logic conv_abort_o, // Abort pulse
    input wire logic [15:0] temperature_o, // Temperature register
    input wire tsens_regs_t regs_o, // Writable registers
    input wire logic shutdown_o, // Shutdown control
    input wire logic fault_queue_en_o // Fault queue control
);
    int gap_cnt;
    int low_cnt;
    logic [2:0] flag_exp;
    assign flag_exp = (ADDR_PINS == 2) ? status_flags_i :
        (ADDR_PINS == 3) ? {1'b0, status_flags_i[1:0]} : 3'h0;
    // Slack in the bounds covers the two-flop reset release and abort lag
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) gap_cnt <= 0;
        else if (conv_done_o || conv_abort_o || shutdown_o) gap_cnt <= 0;
        else gap_cnt <= gap_cnt + 1;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) low_cnt <= 0;
        else if (scl_i) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sda_low_const_a: assert property (sda_o == 1'b0)
        else $error("data drive level not low");
    conv_pulse_a: assert property (conv_done_o |=> !conv_done_o)
        else $error("result pulse longer than one cycle");
    conv_gap_min_a: assert property (conv_done_o |-> gap_cnt >= CONV_CYCLES - 3)
        else $error("results closer than conversion period");
    conv_gap_max_a: assert property (!shutdown_o |-> gap_cnt <= CONV_CYCLES + 4)
        else $error("conversion result overdue");
    temp_value_a: assert property (conv_done_o && $stable(temp_sample_i) &&
        $stable(status_flags_i) |=> temperature_o == {$past(temp_sample_i), $past(flag_exp)})
        else $error("temperature register content wrong");
    conf_bits_a: assert property ($stable(regs_o.config_byte) |->
        shutdown_o == regs_o.config_byte[CONF_SHUTDOWN_BIT] &&
        fault_queue_en_o == regs_o.config_byte[CONF_FAULTQ_BIT])
        else $error("control outputs differ from configuration");
    shutdown_hold_a: assert property ($past(shutdown_o) |-> !conv_done_o)
        else $error("result stored while shut down");
    abort_pulse_a: assert property (conv_abort_o |-> !scl_i ##1 !conv_abort_o)
        else $error("abort pulse misplaced");
    drive_edge_a: assert property ($fell(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
        else $error("data driven while clock high");
    bus_timeout_a: assert property (low_cnt > TIMEOUT_CYCLES + 3 &&
        !regs_o.config_byte[CONF_TO_DIS_BIT] |-> sda_oe_n_o)
        else $error("data still driven after clock low timeout");
    cover property (conv_done_o);
    cover property (conv_abort_o);
    cover property ($fell(sda_oe_n_o));
endmodule // tsens_smbus_chk
bind tsens_smbus_slave tsens_smbus_chk #(.ADDR_PINS(ADDR_PINS), .CONV_CYCLES(CONV_CYCLES),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .temp_sample_i(temp_sample_i),
    .status_flags_i(status_flags_i), .conv_done_o(conv_done_o), .conv_abort_o(conv_abort_o),
    .temperature_o(temperature_o), .regs_o(regs_o), .shutdown_o(shutdown_o),
    .fault_queue_en_o(fault_queue_en_o));
`default_nettype wire

// [tsens_host_bfm.sv]
`timescale 1ns/1ps
`default_nettype none
module tsens_host_bfm (
    input wire logic clk_i, // Bench clock
    input wire logic sda_i, // Resolved data line
    output logic scl_o, // Serial clock
    output logic sda_o // Data drive, high is released
);
    localparam int HALF = 10;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start();
        sda_o = 1'b1;
        w(HALF);
        scl_o = 1'b1;
        w(HALF);
        sda_o = 1'b0;
        w(HALF);
        scl_o = 1'b0;
        w(2);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        w(HALF);
        scl_o = 1'b1;
        w(HALF);
        sda_o = 1'b1;
        w(HALF);
    endtask
    // Data changes two cycles after the clock fall to keep hold time
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        w(HALF - 2);
        scl_o = 1'b1;
        w(HALF);
        r = sda_i;
        scl_o = 1'b0;
        w(2);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
        output logic ack_out);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, ack_out);
    endtask
    task automatic addr_bits(input logic [7:0] d);
        logic r;
        start();
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    endtask
    task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input int wlen,
        input logic [15:0] wd, input int rlen, output logic [15:0] rd, output logic nack);
        logic [7:0] q;
        logic k;
        rd = 16'h0000;
        start();
        byte_io({a, 1'b0}, 1'b1, q, nack);
        byte_io(cmd, 1'b1, q, k);
        for (int i = 0; i < wlen; i++) byte_io(wd[15 - 8 * i -: 8], 1'b1, q, k);
        if (rlen > 0) begin
            start();
            byte_io({a, 1'b1}, 1'b1, q, k);
            for (int i = 0; i < rlen; i++) begin
                byte_io(8'hFF, i == rlen - 1, q, k);
                rd = {rd[7:0], q};
            end
        end
        stop();
    endtask
endmodule // tsens_host_bfm
`default_nettype wire

// [temp_sensor_smbus_slave_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module temp_sensor_smbus_slave_tb_top;
    import tsens_pkg::*;
    localparam int CONV = 200;
    localparam int TMO = 500;
    localparam logic [6:0] DEV = 7'h4D;
    localparam logic [12:0] TS_A = 13'h1F38; // Minus 12.5 degrees
    localparam logic [12:0] TS_B = 13'h0190; // Plus 25 degrees
    typedef struct packed {
        logic [7:0] cmd; logic [1:0] wlen; logic [15:0] wd; logic [1:0] rlen; logic [15:0] exp;
    } tsens_row_t;
    localparam tsens_row_t ROWS [8] = '{{PTR_CONF, 2'h1, 16'h0800, 2'h1, 16'h0008},
        {PTR_CONF, 2'h0, 16'h0000, 2'h2, 16'h0800}, {PTR_HYST, 2'h2, 16'h1234, 2'h2, 16'h1234},
        {PTR_TLOW, 2'h2, 16'hFF80, 2'h2, 16'hFF80}, {PTR_THIGH, 2'h1, 16'h5A00, 2'h2, 16'h5A00},
        {PTR_TEMP, 2'h2, 16'hFFFF, 2'h2, {TS_A, 3'h3}}, {8'h07, 2'h2, 16'hBEEF, 2'h2, 16'h0000},
        {PTR_HYST, 2'h0, 16'h0000, 2'h1, 16'h0012}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, host_sda, dev_sda, sda_oe_n, conv_done, conv_abort, shutdown, fault_q, nack;
    logic oe_small, oe_wide;
    logic [15:0] temp_small;
    logic [3:0] addr_sel = 4'h5;
    logic [12:0] temp_sample = TS_A;
    logic [2:0] flags = 3'h7;
    logic [15:0] temperature, rd;
    tsens_regs_t regs;
    int errors = 0, samples_checked = 0, dones = 0, aborts = 0, mark = 0;
    wire sda_bus = host_sda & (sda_oe_n | dev_sda) & oe_small & oe_wide;
    tsens_smbus_slave #(.ADDR_PINS(3), .CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) u_dut (
        .clk_i(clk), .nrst_i(rst_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(dev_sda),
        .sda_oe_n_o(sda_oe_n), .address_select_i(addr_sel), .temp_sample_i(temp_sample),
        .status_flags_i(flags), .conv_done_o(conv_done), .conv_abort_o(conv_abort),
        .temperature_o(temperature), .regs_o(regs), .shutdown_o(shutdown),
        .fault_queue_en_o(fault_q));
    // Other variants share the bus at addresses that no other test uses
    tsens_smbus_slave #(.ADDR_PINS(4), .CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) u_dut_small (
        .clk_i(clk), .nrst_i(rst_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(),
        .sda_oe_n_o(oe_small), .address_select_i(4'h3), .temp_sample_i(temp_sample),
        .status_flags_i(flags), .conv_done_o(), .conv_abort_o(), .temperature_o(temp_small),
        .regs_o(), .shutdown_o(), .fault_queue_en_o());
    tsens_smbus_slave #(.ADDR_PINS(2), .BASE_ADDR(7'h20), .CONV_CYCLES(CONV),
        .TIMEOUT_CYCLES(TMO)) u_dut_wide (
        .clk_i(clk), .nrst_i(rst_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(),
        .sda_oe_n_o(oe_wide), .address_select_i(4'h2), .temp_sample_i(temp_sample),
        .status_flags_i(flags), .conv_done_o(), .conv_abort_o(), .temperature_o(),
        .regs_o(), .shutdown_o(), .fault_queue_en_o());
    tsens_host_bfm u_host (.clk_i(clk), .sda_i(sda_bus), .scl_o(scl), .sda_o(host_sda));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (conv_done === 1'b1) dones++;
        if (conv_abort === 1'b1) aborts++;
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        mark = dones;
        while (dones == mark && n < 4 * CONV) begin
            @(negedge clk);
            n++;
        end
        `CHK(dones - mark, 1)
        @(negedge clk);
    endtask
    initial begin
        #400000;
        errors++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        `CHK({sda_oe_n, regs, temperature}, 73'h1_0000_0000_0000_0000_00)
        $display("test reset done");
        wait_done();
        `CHK(temperature, {TS_A, 3'h3})
        temp_sample = TS_B;
        flags = 3'h4;
        wait_done();
        wait_done();
        `CHK(temperature, {TS_B, 3'h0})
        temp_sample = TS_A;
        flags = 3'h7;
        wait_done();
        $display("test conversion done");
        mark = aborts;
        foreach (ROWS[i]) begin
            u_host.xfer(DEV, ROWS[i].cmd, ROWS[i].wlen, ROWS[i].wd, ROWS[i].rlen, rd, nack);
            `CHK({nack, rd}, {1'b0, ROWS[i].exp})
        end
        `CHK(aborts - mark, 1)
        `CHK({regs, shutdown, fault_q}, {8'h08, 16'h1234, 16'hFF80, 16'h5A00, 2'h1})
        u_host.xfer(7'h43, PTR_HYST, 2, 16'h1234, 2, rd, nack);
        `CHK({nack, rd}, 17'h0_0000)
        u_host.xfer(7'h43, PTR_TEMP, 0, 16'h0000, 2, rd, nack);
        `CHK({rd, temp_small}, {TS_A, 3'h0, TS_A, 3'h0})
        u_host.xfer(7'h22, PTR_TEMP, 0, 16'h0000, 2, rd, nack);
        `CHK({nack, rd}, {1'b0, TS_A, 3'h7})
        $display("test registers done");
        // Pin three is unused in this variant, so it toggles freely
        for (logic [3:0] p = 4'h0; p < 4'h8; p++) begin
            addr_sel = {p[0], p[2:0]};
            u_host.xfer({4'h9, p[2:0]}, PTR_CONF, 1, 16'h0800, 0, rd, nack);
            `CHK(nack, 1'b0)
            u_host.xfer({4'h9, p[2:0] ^ 3'h1}, PTR_CONF, 1, 16'h0800, 0, rd, nack);
            `CHK(nack, 1'b1)
        end
        addr_sel = 4'h5;
        $display("test address done");
        u_host.xfer(DEV, PTR_CONF, 1, 16'h0100, 0, rd, nack);
        mark = dones;
        repeat (3 * CONV) @(negedge clk);
        `CHK({shutdown, dones - mark}, {1'b1, 32'h0})
        u_host.xfer(DEV, PTR_CONF, 1, 16'h0000, 0, rd, nack);
        wait_done();
        $display("test shutdown done");
        for (int dis = 0; dis < 2; dis++) begin
            u_host.xfer(DEV, PTR_CONF, 1, {dis[0], 15'h0000}, 0, rd, nack);
            u_host.addr_bits({DEV, 1'b0});
            repeat (4) @(negedge clk);
            `CHK(sda_oe_n, 1'b0)
            repeat (TMO + 20) @(negedge clk);
            `CHK(sda_oe_n, dis[0] ? 1'b0 : 1'b1)
            u_host.bit_io(1'b1, nack);
            u_host.stop();
            `CHK(nack, ~dis[0])
        end
        u_host.xfer(DEV, PTR_CONF, 1, 16'h0000, 1, rd, nack);
        `CHK(rd, 16'h0000)
        $display("test timeout done");
        close_out();
    end
endmodule // temp_sensor_smbus_slave_tb_top
`default_nettype wire
